// ===== rtl/dac_input_update_control.sv
/*
  Digital control front end of a 10-bit converter: configuration and data
  registers on a classic Wishbone slave, shadow value update by write or by
  event trigger, alignment, output routing and enable.
  Assumes event flags are synchronous to clk_sys_in and the analog core
  takes dac_value_out together with the enable and routing outputs.

*/
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "dac_params.svh"

module dac_input_update_control
  import dac_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Wishbone classic slave.
  input wire logic cyc_in,
  input wire logic stb_in,
  input wire logic we_in,
  input wire logic [3:0] adr_in,
  input wire logic [3:0] sel_in,
  input wire logic [31:0] dat_in,
  output logic [31:0] dat_out,
  output logic ack_out,
  // On-chip event flags, one per trigger source code.
  input wire logic [`TRIG_SOURCES-1:0] event_flags_in,
  // Analog core controls.
  output logic [`DAC_BITS-1:0] dac_value_out,
  output logic converter_enable_out,
  output logic analog_output_pin_enable_out,
  output logic update_pulse_out,
  output logic conversion_busy_out
);

  control_state_type state;
  control_state_type next_state;

  logic trigger_edge;
  logic bus_access;
  logic write_strobe;
  logic write_high;
  logic write_low;
  logic write_config;
  logic auto_trigger_enable;
  logic left_align_select;
  logic [`TRIG_SEL_BITS-1:0] trigger_select_field;
  logic trigger_update;
  logic load_shadow;
  logic [7:0] new_high;
  logic [7:0] new_low;
  logic [`DAC_BITS-1:0] composed_value;
  logic [31:0] read_mux;

  // Configuration fields as software left them.
  assign auto_trigger_enable = state.converter_config[`CFG_AUTO_TRIGGER_BIT];
  assign left_align_select = state.converter_config[`CFG_LEFT_ALIGN_BIT];
  assign trigger_select_field =
    state.converter_config[`CFG_TRIGGER_SEL_MSB:`CFG_TRIGGER_SEL_LSB];

  // Source order of event_flags_in follows trigger_source_type codes 0 to 7.
  trigger_edge_detect u_edge (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .flags_in(event_flags_in),
    .select_in(trigger_select_field),
    .edge_out(trigger_edge)
  );

  // A write takes effect in the cycle that ack is high, exactly once per access.
  assign bus_access = cyc_in & stb_in;
  assign write_strobe = bus_access & we_in & state.ack & sel_in[0];
  assign write_config = write_strobe & (adr_in == `OFS_CONFIG);
  assign write_high = write_strobe & (adr_in == `OFS_VALUE_HIGH);
  assign write_low = write_strobe & (adr_in == `OFS_VALUE_LOW);

  // Byte values as they will stand after this cycle's write.
  assign new_high = write_high ? dat_in[7:0] : state.converter_value_high;
  assign new_low = write_low ? dat_in[7:0] : state.converter_value_low;

  // Placement of the 10-bit value in the two bytes, sampled at load time only.
  always_comb begin
    if (left_align_select) begin
      composed_value = {new_high, new_low[7:6]};
    end else begin
      composed_value = {new_high[1:0], new_low};
    end
  end

  // A trigger counts only in auto mode, with no half-written pair and no
  // triggered conversion running; a late edge is dropped, not queued.
  // A low byte write in the same cycle also blocks it, so a fresh low byte
  // never reaches the converter beside a stale high byte.
  assign trigger_update = auto_trigger_enable & trigger_edge
                        & ~state.low_lock
                        & ~state.busy
                        & ~write_low;

  // Direct mode loads on each high byte write, auto mode only on triggers.
  assign load_shadow = (~auto_trigger_enable & write_high) | trigger_update;

  // Register readback; the shadow value itself is not readable.
  always_comb begin
    read_mux = 32'h0000_0000;
    case (adr_in)
      `OFS_CONFIG: begin
        read_mux[7:0] = state.converter_config;
      end
      `OFS_VALUE_HIGH: begin
        read_mux[7:0] = state.converter_value_high;
      end
      `OFS_VALUE_LOW: begin
        read_mux[7:0] = state.converter_value_low;
      end
      `OFS_STATUS: begin
        read_mux[`STAT_BUSY_BIT] = state.busy;
        read_mux[`STAT_LOCK_BIT] = state.low_lock;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  // Next-state logic for bus, registers, shadow and conversion timer.
  always_comb begin
    next_state = state;
    next_state.update_pulse = 1'b0;

    // Ack rises one cycle after the request and falls the cycle after.
    next_state.ack = bus_access & ~state.ack;
    if (bus_access & ~state.ack) begin
      next_state.read_data = read_mux;
    end

    if (write_config) begin
      next_state.converter_config = dat_in[7:0];
    end
    if (write_high) begin
      next_state.converter_value_high = dat_in[7:0];
    end
    if (write_low) begin
      next_state.converter_value_low = dat_in[7:0];
    end

    // Lock after a low byte write, released by the high byte write.
    if (write_low) begin
      next_state.low_lock = 1'b1;
    end else if (write_high) begin
      next_state.low_lock = 1'b0;
    end

    // The shadow is the only value the converter sees, never half updated.
    if (load_shadow) begin
      next_state.shadow_value = composed_value;
      next_state.update_pulse = 1'b1;
    end

    // Triggered conversion timer, edges inside it are ignored.
    if (trigger_update) begin
      next_state.busy = 1'b1;
      next_state.busy_count = `CONV_CNT_BITS'(`CONV_CYCLES - 1);
    end else if (state.busy) begin
      if (state.busy_count == '0) begin
        next_state.busy = 1'b0;
      end else begin
        next_state.busy_count = state.busy_count - `CONV_CNT_BITS'(1);
      end
    end
  end

  // All state clears to zero at reset.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs.
  assign ack_out = state.ack;
  assign dat_out = state.read_data;
  assign dac_value_out = state.shadow_value;
  assign converter_enable_out = state.converter_config[`CFG_ENABLE_BIT];
  assign analog_output_pin_enable_out = state.converter_config[`CFG_PIN_ENABLE_BIT];
  assign update_pulse_out = state.update_pulse;
  assign conversion_busy_out = state.busy;

endmodule

// ===== rtl/trigger_edge_detect.sv
/*
  Rising edge detector for the on-chip event flags, with source selection.
  Assumes the flags come from logic on the same clock, so no synchroniser.
*/
`timescale 1ns/1ps
`include "dac_params.svh"

module trigger_edge_detect
  import dac_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Event flags and selection.
  input wire logic [`TRIG_SOURCES-1:0] flags_in,
  input wire logic [`TRIG_SEL_BITS-1:0] select_in,
  // Rising edge of the selected flag.
  output logic edge_out
);

  edge_state_type state;
  edge_state_type next_state;
  logic [`TRIG_SOURCES-1:0] rise;

  // Each source is watched on its own so a change of selection needs no history.
  genvar i;
  generate
    for (i = 0; i < `TRIG_SOURCES; i++) begin : g_rise
      assign rise[i] = flags_in[i] & ~state.prev_flags[i];
    end
  endgenerate

  // Pick the selected source, interrupt enables play no part here.
  assign edge_out = rise[select_in];

  always_comb begin
    next_state = state;
    next_state.prev_flags = flags_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

// ===== shared/dac_params.svh
/*
  Constants for the converter input update control block: register offsets,
  field positions, reset values and the conversion time.
  Assumes a 32-bit classic Wishbone slave with byte addresses and a 20 MHz clock.
*/
`ifndef DAC_PARAMS_SVH
`define DAC_PARAMS_SVH

// Register byte offsets, one aligned word each.
`define OFS_CONFIG 4'h0
`define OFS_VALUE_HIGH 4'h4
`define OFS_VALUE_LOW 4'h8
`define OFS_STATUS 4'hC

// Configuration field positions.
`define CFG_AUTO_TRIGGER_BIT 7
`define CFG_TRIGGER_SEL_MSB 6
`define CFG_TRIGGER_SEL_LSB 4
`define CFG_LEFT_ALIGN_BIT 2
`define CFG_PIN_ENABLE_BIT 1
`define CFG_ENABLE_BIT 0

// Status field positions.
`define STAT_BUSY_BIT 11
`define STAT_LOCK_BIT 10

// Widths and reset values.
`define DAC_BITS 10
`define TRIG_SOURCES 8
`define TRIG_SEL_BITS 3
`define BYTE_RESET 8'h00
`define VALUE_RESET 10'h000

// Conversion time of a triggered update and its length in clock cycles.
`define CLK_PERIOD_NS 50
`define CONV_TIME_NS 1000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_BITS 5

`endif

// ===== shared/dac_pkg.sv
/*
  Types for the converter input update control block.
  Assumes dac_params.svh is on the include path.
*/
`include "dac_params.svh"

package dac_pkg;

  // Trigger source codes of the select field.
  typedef enum logic [`TRIG_SEL_BITS-1:0] {
    TRIG_COMPARATOR0,
    TRIG_COMPARATOR1,
    TRIG_EXT_IRQ0,
    TRIG_TIMER8_COMPARE,
    TRIG_TIMER8_OVERFLOW,
    TRIG_TIMER16_COMPARE_B,
    TRIG_TIMER16_OVERFLOW,
    TRIG_TIMER16_CAPTURE
  } trigger_source_type;

  // State of the trigger edge detector.
  typedef struct packed {
    logic [`TRIG_SOURCES-1:0] prev_flags;
  } edge_state_type;

  // State of the control block.
  typedef struct packed {
    logic [7:0] converter_config;
    logic [7:0] converter_value_high;
    logic [7:0] converter_value_low;
    logic [`DAC_BITS-1:0] shadow_value;
    logic low_lock;
    logic busy;
    logic [`CONV_CNT_BITS-1:0] busy_count;
    logic update_pulse;
    logic ack;
    logic [31:0] read_data;
  } control_state_type;

endpackage

// ===== verif/dac_input_update_control_tb_top.sv
/* Self-checking bench for the converter input update block.
   Assumes dac_params.svh is on the include path; the bench drives all ports. */
`timescale 1ns/1ps
`include "dac_params.svh"
module dac_input_update_control_tb_top;
  import dac_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cyc_in = 1'b0, stb_in = 1'b0, we_in = 1'b0;
  logic [3:0] adr_in = 4'h0, sel_in = 4'h0;
  logic [31:0] dat_in = 32'h0, dat_out;
  logic [7:0] event_flags_in = 8'h00;
  logic ack_out, converter_enable_out, analog_output_pin_enable_out;
  logic update_pulse_out, conversion_busy_out;
  logic [9:0] dac_value_out;
  logic [31:0] seed = 32'hA26F;
  logic [31:0] rd_q[$];
  logic [9:0] val_q[$];
  int n_mismatch = 0, check_count = 0;

  dac_input_update_control DUT (.*);

  // Free-running 20 MHz system clock.
  always #25 clk_sys_in = ~clk_sys_in;

  function automatic logic [9:0] pack(input logic [7:0] l, h, input logic left);
    return left ? {h, l[7:6]} : {h[1:0], l};
  endfunction

  // One step of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  // One classic cycle; for a read, d is the expected byte, noted first.
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    if (!w) rd_q.push_back({24'h0, d});
    @(posedge clk_sys_in);
    cyc_in <= 1'b1;
    stb_in <= 1'b1;
    we_in <= w;
    adr_in <= a;
    sel_in <= 4'h1;
    dat_in <= {seed[31:8], d};
    do @(posedge clk_sys_in); while (ack_out !== 1'b1);
    cyc_in <= 1'b0;
    stb_in <= 1'b0;
  endtask

  // Raise one event flag for a single cycle.
  task automatic fire(input int b);
    @(posedge clk_sys_in);
    event_flags_in[b] <= 1'b1;
    @(posedge clk_sys_in);
    event_flags_in[b] <= 1'b0;
  endtask

  // Takes the oldest note whenever read data or a shadow load appears.
  always @(posedge clk_sys_in) begin
    if (ack_out && !we_in) chk("read data", rd_q.pop_front(), dat_out);
    if (update_pulse_out) begin
      if (val_q.size() == 0) chk("unexpected load", 32'h0, 32'h1);
      else chk("shadow value", {22'h0, val_q.pop_front()}, {22'h0, dac_value_out});
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short; the full run needs well under a tenth of this.
  initial begin
    #2000000;
    n_mismatch++;
    conclude();
  end

  // Direct and triggered updates for every trigger code and both alignments.
  initial begin
    logic [7:0] l, h, c;
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    wb(0, `OFS_CONFIG, 8'h00);
    wb(0, `OFS_VALUE_HIGH, 8'h00);
    wb(0, `OFS_VALUE_LOW, 8'h00);
    wb(0, 4'h2, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      l = seed[7:0];
      h = seed[15:8];
      c = {1'b0, i[2:0], 1'b0, i[0], i[1], 1'b1};
      wb(1, `OFS_CONFIG, c);
      wb(0, `OFS_CONFIG, c);
      chk("converter enable", {31'h0, c[0]}, {31'h0, converter_enable_out});
      chk("pin enable", {31'h0, c[1]}, {31'h0, analog_output_pin_enable_out});
      wb(1, `OFS_VALUE_LOW, l);
      val_q.push_back(pack(l, h, c[2]));
      wb(1, `OFS_VALUE_HIGH, h);
      wb(0, `OFS_VALUE_LOW, l);
      wb(1, `OFS_CONFIG, c ^ 8'h04);
      val_q.push_back(pack(l, h, !c[2]));
      wb(1, `OFS_VALUE_HIGH, h);
      wb(1, `OFS_CONFIG, c | 8'h80);
      fire(i ^ 1);
      wb(1, `OFS_VALUE_LOW, l);
      fire(i);
      wb(1, `OFS_VALUE_HIGH, h);
      val_q.push_back(pack(l, h, c[2]));
      fire(i);
      fire(i);
      chk("busy", 32'h1, {31'h0, conversion_busy_out});
      repeat (`CONV_CYCLES + 2) @(posedge clk_sys_in);
      chk("busy", 32'h0, {31'h0, conversion_busy_out});
      h = seed[23:16];
      wb(1, `OFS_VALUE_HIGH, h);
      val_q.push_back(pack(l, h, c[2]));
      fire(i);
      repeat (`CONV_CYCLES + 2) @(posedge clk_sys_in);
      val_q.push_back(pack(l, h, c[2]));
      fire(i);
      repeat (`CONV_CYCLES + 2) @(posedge clk_sys_in);
    end
    // A reset in mid-run must clear every register that the loop left set.
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    wb(0, `OFS_CONFIG, 8'h00);
    wb(0, `OFS_VALUE_HIGH, 8'h00);
    wb(0, `OFS_VALUE_LOW, 8'h00);
    chk("value after reset", 32'h0, {22'h0, dac_value_out});
    chk("loads left", 32'h0, val_q.size());
    conclude();
  end
endmodule

// ===== verif/dac_update_monitor.sv
/* Checker for the converter input update block, bound to its ports.
   Assumes dac_params.svh is on the include path and one clock domain. */
`timescale 1ns/1ps
`include "dac_params.svh"
module dac_update_monitor (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Bus side.
  input wire logic we_in,
  input wire logic [3:0] adr_in,
  input wire logic [3:0] sel_in,
  input wire logic [31:0] dat_in,
  input wire logic ack_out,
  // Events and converter side.
  input wire logic [`TRIG_SOURCES-1:0] event_flags_in,
  input wire logic [`DAC_BITS-1:0] dac_value_out,
  input wire logic converter_enable_out,
  input wire logic analog_output_pin_enable_out,
  input wire logic update_pulse_out,
  input wire logic conversion_busy_out
);
  logic wr;
  logic [7:0] cfg;
  logic lock;
  logic [`TRIG_SOURCES-1:0] flags_d;
  logic sel_rise;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // A write takes effect at the edge where ack is seen.
  assign wr = ack_out && we_in && sel_in[0];
  // Mirror of the configuration and the low byte lock, fed from bus writes.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cfg <= 8'h00;
      lock <= 1'b0;
      flags_d <= 8'h00;
    end else begin
      flags_d <= event_flags_in;
      if (wr && adr_in == `OFS_CONFIG) cfg <= dat_in[7:0];
      if (wr && adr_in == `OFS_VALUE_LOW) lock <= 1'b1;
      if (wr && adr_in == `OFS_VALUE_HIGH) lock <= 1'b0;
    end
  end
  // Rising edge of the flag that the mirrored select field points at.
  assign sel_rise = event_flags_in[cfg[`CFG_TRIGGER_SEL_MSB:`CFG_TRIGGER_SEL_LSB]]
    & ~flags_d[cfg[`CFG_TRIGGER_SEL_MSB:`CFG_TRIGGER_SEL_LSB]];
  reset_clear_a: assert property ($past(sys_rst_in) |-> dac_value_out == 10'h000
    && !converter_enable_out) else $error("outputs not clear after reset");
  value_hold_a: assert property (!update_pulse_out |-> $stable(dac_value_out))
    else $error("shadow value moved without a load");
  direct_load_a: assert property (wr && adr_in == `OFS_VALUE_HIGH && !cfg[7]
    |=> update_pulse_out) else $error("high write did not load");
  auto_only_a: assert property (update_pulse_out && cfg[7]
    |-> $rose(conversion_busy_out)) else $error("auto mode load without trigger");
  trig_gate_a: assert property ($rose(conversion_busy_out)
    |-> $past(cfg[7]) && !$past(lock)) else $error("trigger load while not allowed");
  edge_cause_a: assert property ($rose(conversion_busy_out) |-> $past(sel_rise))
    else $error("trigger load without a selected flag edge");
  trig_take_a: assert property (sel_rise && cfg[7] && !lock && !conversion_busy_out
    && !(wr && adr_in == `OFS_VALUE_LOW) |=> update_pulse_out && conversion_busy_out)
    else $error("selected trigger edge not taken");
  no_retrig_a: assert property (update_pulse_out && !$past(ack_out)
    |-> $rose(conversion_busy_out)) else $error("trigger accepted while busy");
  busy_len_a: assert property ($rose(conversion_busy_out) |-> conversion_busy_out[*8]
    ##12 conversion_busy_out ##1 !conversion_busy_out) else $error("busy length wrong");
  enable_out_a: assert property (cfg == $past(cfg) |-> converter_enable_out == cfg[0]
    && analog_output_pin_enable_out == cfg[1]) else $error("enable outputs wrong");
endmodule

bind dac_input_update_control dac_update_monitor monitor (.*);
